// ==== rtl/dppio_defines.vh ====
// Register offsets, field positions and reset values of the parallel I/O block.
`ifndef DPPIO_DEFINES_VH
`define DPPIO_DEFINES_VH

`define DPPIO_CH_A_BASE    8'h00
`define DPPIO_CH_B_BASE    8'h20
`define DPPIO_OFS_DATA     8'h00
`define DPPIO_OFS_MODE     8'h04
`define DPPIO_OFS_DIR      8'h08
`define DPPIO_OFS_MASK     8'h0c
`define DPPIO_OFS_MATCH    8'h10
`define DPPIO_IRQ_STATUS   8'h40
`define DPPIO_IRQ_MASK     8'h44
`define DPPIO_IRQ_PRIO     8'h48

`define DPPIO_MODE_OUT     2'h0
`define DPPIO_MODE_IN      2'h1
`define DPPIO_MODE_BIDIR   2'h2
`define DPPIO_MODE_BIT     2'h3

`define DPPIO_IRQ_A_XFER   0
`define DPPIO_IRQ_A_MATCH  1
`define DPPIO_IRQ_B_XFER   2
`define DPPIO_IRQ_B_MATCH  3

`define DPPIO_MODE_RST     2'h1
`define DPPIO_DIR_RST      8'h00
`define DPPIO_MASK_RST     8'hff
`define DPPIO_MATCH_RST    8'h00
`define DPPIO_IRQ_MASK_RST 4'h0

`endif

// ==== rtl/dppio_chan.v ====
// One parallel channel: data registers, strobe/ready handshake and bit matching.
`timescale 1ns/10ps
`include "dppio_defines.vh"

module dppio_chan
#(
   parameter WIDTH = 8,
   parameter BIDIR = 1
)
(
   // Clock and reset
   input  wire             clk_i,
   input  wire             reset_i,
   // Configuration
   input  wire [1:0]       mode_i,
   input  wire [WIDTH-1:0] dir_i,
   input  wire [WIDTH-1:0] mask_i,
   input  wire [WIDTH-1:0] match_i,
   // Host side
   input  wire             host_wr_i,
   input  wire [WIDTH-1:0] host_wdata_i,
   input  wire             host_rd_i,
   output reg  [WIDTH-1:0] in_data_o,
   // Peripheral side
   input  wire [WIDTH-1:0] port_i,
   output reg  [WIDTH-1:0] port_o,
   output reg  [WIDTH-1:0] port_oe_n_o,
   input  wire             stb_n_i,
   output reg              rdy_o,
   // Events
   output reg              xfer_evt_o,
   output reg              match_evt_o
);

   reg              stb_q;
   reg              out_full;
   reg              in_full;
   reg              match_q;
   wire             stb_fall;
   wire [WIDTH-1:0] mon;
   wire             hit;

   assign stb_fall = stb_q & ~stb_n_i;
   assign mon      = ~mask_i & ~dir_i;
   assign hit      = (mode_i == `DPPIO_MODE_BIT) && (mon != {WIDTH{1'b0}}) &&
                     (((port_i ^ match_i) & mon) == {WIDTH{1'b0}});

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         stb_q       <= 1'b1;
         out_full    <= 1'b0;
         in_full     <= 1'b0;
         match_q     <= 1'b0;
         in_data_o   <= {WIDTH{1'b0}};
         port_o      <= {WIDTH{1'b0}};
         port_oe_n_o <= {WIDTH{1'b1}};
         rdy_o       <= 1'b0;
         xfer_evt_o  <= 1'b0;
         match_evt_o <= 1'b0;
      end
      else
      begin
         stb_q       <= stb_n_i;
         match_q     <= hit;
         match_evt_o <= hit & ~match_q;
         xfer_evt_o  <= 1'b0;
         if (host_wr_i)
            port_o <= host_wdata_i;
         case (mode_i)
            `DPPIO_MODE_OUT:
            begin
               port_oe_n_o <= {WIDTH{1'b0}};
               if (host_wr_i)
                  out_full <= 1'b1;
               else if (stb_fall)
                  out_full <= 1'b0;
               rdy_o      <= host_wr_i | (out_full & ~stb_fall);
               xfer_evt_o <= stb_fall;
            end
            `DPPIO_MODE_BIDIR:
            begin
               // Strobe drains a pending output byte first, else captures input.
               port_oe_n_o <= {WIDTH{~(out_full & (BIDIR != 0))}};
               if (host_wr_i)
                  out_full <= 1'b1;
               else if (stb_fall)
                  out_full <= 1'b0;
               if (stb_fall && !out_full && !in_full)
               begin
                  in_data_o <= port_i;
                  in_full   <= 1'b1;
               end
               else if (host_rd_i)
                  in_full <= 1'b0;
               rdy_o      <= (host_wr_i | out_full | ~in_full) & ~stb_fall;
               xfer_evt_o <= stb_fall;
            end
            `DPPIO_MODE_BIT:
            begin
               port_oe_n_o <= ~dir_i;
               out_full    <= 1'b0;
               in_full     <= 1'b0;
               rdy_o       <= 1'b0;
            end
            default:
            begin
               port_oe_n_o <= {WIDTH{1'b1}};
               out_full    <= 1'b0;
               // A strobe while the input buffer is full is dropped, even in the same cycle as the host read.
               if (stb_fall && !in_full)
               begin
                  in_data_o <= port_i;
                  in_full   <= 1'b1;
               end
               else if (host_rd_i)
                  in_full <= 1'b0;
               rdy_o      <= ~in_full & ~stb_fall;
               xfer_evt_o <= stb_fall & ~in_full;
            end
         endcase
      end
   end

endmodule

// ==== rtl/dppio_top.v ====
// Top of the dual-channel parallel I/O block with APB registers and interrupts.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "dppio_defines.vh"

module dppio_top
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input  wire             clk_i,
   input  wire             reset_i,

   // APB slave
   input  wire             psel_i,
   input  wire             penable_i,
   input  wire             pwrite_i,
   input  wire [7:0]       paddr_i,
   input  wire [31:0]      pwdata_i,
   output reg  [31:0]      prdata_o,
   output wire             pready_o,
   output reg              pslverr_o,

   // Channel A pins
   input  wire [WIDTH-1:0] porta_i,
   output wire [WIDTH-1:0] porta_o,
   output wire [WIDTH-1:0] porta_oe_n_o,
   input  wire             stb_a_n_i,
   output wire             rdy_a_o,

   // Channel B pins
   input  wire [WIDTH-1:0] portb_i,
   output wire [WIDTH-1:0] portb_o,
   output wire [WIDTH-1:0] portb_oe_n_o,
   input  wire             stb_b_n_i,
   output wire             rdy_b_o,

   // Interrupt and priority chain
   output wire             int_o,
   input  wire             prio_in_i,
   output wire             prio_out_o
);

   // True when the address hits the given offset of the given channel.
   function chan_hit;
      input [7:0] addr;
      input [7:0] base;
      input [7:0] ofs;
      begin
         chan_hit = (addr == (base | ofs));
      end
   endfunction

   // Read view of one channel's register set.
   function [WIDTH-1:0] chan_read;
      input [7:0]       ofs;
      input [WIDTH-1:0] data;
      input [1:0]       mode;
      input [WIDTH-1:0] dir;
      input [WIDTH-1:0] mask;
      input [WIDTH-1:0] match;
      begin
         case (ofs)
            `DPPIO_OFS_DATA:  chan_read = data;
            `DPPIO_OFS_MODE:  chan_read = {{(WIDTH-2){1'b0}}, mode};
            `DPPIO_OFS_DIR:   chan_read = dir;
            `DPPIO_OFS_MASK:  chan_read = mask;
            `DPPIO_OFS_MATCH: chan_read = match;
            default:          chan_read = {WIDTH{1'b0}};
         endcase
      end
   endfunction

   // True when the offset names a channel register.
   function chan_ofs_ok;
      input [7:0] ofs;
      begin
         case (ofs)
            `DPPIO_OFS_DATA,
            `DPPIO_OFS_MODE,
            `DPPIO_OFS_DIR,
            `DPPIO_OFS_MASK,
            `DPPIO_OFS_MATCH: chan_ofs_ok = 1'b1;
            default:          chan_ofs_ok = 1'b0;
         endcase
      end
   endfunction

   // Per-channel control registers.
   reg  [1:0]       mode_a;
   reg  [1:0]       mode_b;
   reg  [WIDTH-1:0] dir_a;
   reg  [WIDTH-1:0] dir_b;
   reg  [WIDTH-1:0] mask_a;
   reg  [WIDTH-1:0] mask_b;
   reg  [WIDTH-1:0] match_a;
   reg  [WIDTH-1:0] match_b;

   // Interrupt registers.
   reg  [3:0]       irq_status;
   reg  [3:0]       irq_mask;
   reg  [3:0]       next_irq_status;

   // Bus decode.
   wire             setup;
   wire             wr_acc;
   wire             rd_setup;
   wire             sel_b;
   wire [7:0]       ch_ofs;
   wire             ch_space;
   wire             mapped;
   reg  [31:0]      next_prdata;

   // Register hits.
   wire             hit_a_data;
   wire             hit_b_data;
   wire             hit_a_mode;
   wire             hit_b_mode;
   wire             hit_status;
   wire             hit_mask;
   wire             hit_prio;

   // Channel outputs.
   wire [WIDTH-1:0] in_data_a;
   wire [WIDTH-1:0] in_data_b;
   wire             xfer_a;
   wire             xfer_b;
   wire             match_evt_a;
   wire             match_evt_b;

   // Interrupt priority.
   wire [3:0]       pending;
   wire             pend_a;
   wire             pend_b;
   reg  [1:0]       prio_code;

   assign setup    = psel_i & ~penable_i;
   assign wr_acc   = psel_i & penable_i & pwrite_i;
   assign rd_setup = setup & ~pwrite_i;
   assign sel_b    = (paddr_i & `DPPIO_CH_B_BASE) != 8'h00;
   assign ch_ofs   = paddr_i & ~`DPPIO_CH_B_BASE;
   assign ch_space = paddr_i < `DPPIO_IRQ_STATUS;
   assign mapped   = (ch_space && chan_ofs_ok(ch_ofs)) ||
                     hit_status ||
                     hit_mask ||
                     hit_prio;

   // Mode hits feed only the write path; channel read data is decoded from ch_ofs, not from the data hits.
   assign hit_a_data = chan_hit(paddr_i, `DPPIO_CH_A_BASE, `DPPIO_OFS_DATA);
   assign hit_b_data = chan_hit(paddr_i, `DPPIO_CH_B_BASE, `DPPIO_OFS_DATA);
   assign hit_a_mode = chan_hit(paddr_i, `DPPIO_CH_A_BASE, `DPPIO_OFS_MODE);
   assign hit_b_mode = chan_hit(paddr_i, `DPPIO_CH_B_BASE, `DPPIO_OFS_MODE);
   assign hit_status = (paddr_i == `DPPIO_IRQ_STATUS);
   assign hit_mask   = (paddr_i == `DPPIO_IRQ_MASK);
   assign hit_prio   = (paddr_i == `DPPIO_IRQ_PRIO);

   // Every access completes in its first access cycle.
   assign pready_o = 1'b1;

   // Control register writes.
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         mode_a   <= `DPPIO_MODE_RST;
         mode_b   <= `DPPIO_MODE_RST;
         dir_a    <= `DPPIO_DIR_RST;
         dir_b    <= `DPPIO_DIR_RST;
         mask_a   <= `DPPIO_MASK_RST;
         mask_b   <= `DPPIO_MASK_RST;
         match_a  <= `DPPIO_MATCH_RST;
         match_b  <= `DPPIO_MATCH_RST;
         irq_mask <= `DPPIO_IRQ_MASK_RST;
      end
      else if (wr_acc)
      begin
         if (hit_a_mode)
            mode_a <= pwdata_i[1:0];
         // Channel B keeps its mode when software asks for bidirectional.
         if (hit_b_mode && pwdata_i[1:0] != `DPPIO_MODE_BIDIR)
            mode_b <= pwdata_i[1:0];
         // Direction and mask stay writable in every mode, so bit mode can be set up first.
         if (chan_hit(paddr_i, `DPPIO_CH_A_BASE, `DPPIO_OFS_DIR))
            dir_a <= pwdata_i[WIDTH-1:0];
         if (chan_hit(paddr_i, `DPPIO_CH_B_BASE, `DPPIO_OFS_DIR))
            dir_b <= pwdata_i[WIDTH-1:0];
         if (chan_hit(paddr_i, `DPPIO_CH_A_BASE, `DPPIO_OFS_MASK))
            mask_a <= pwdata_i[WIDTH-1:0];
         if (chan_hit(paddr_i, `DPPIO_CH_B_BASE, `DPPIO_OFS_MASK))
            mask_b <= pwdata_i[WIDTH-1:0];
         if (chan_hit(paddr_i, `DPPIO_CH_A_BASE, `DPPIO_OFS_MATCH))
            match_a <= pwdata_i[WIDTH-1:0];
         if (chan_hit(paddr_i, `DPPIO_CH_B_BASE, `DPPIO_OFS_MATCH))
            match_b <= pwdata_i[WIDTH-1:0];
         if (hit_mask)
            irq_mask <= pwdata_i[3:0];
      end
   end

   // Sticky status: a new event wins over a write-one-to-clear.
   always @*
   begin
      next_irq_status = irq_status;
      if (wr_acc && hit_status)
         next_irq_status = irq_status & ~pwdata_i[3:0];
      next_irq_status[`DPPIO_IRQ_A_XFER]  = next_irq_status[`DPPIO_IRQ_A_XFER]  | xfer_a;
      next_irq_status[`DPPIO_IRQ_A_MATCH] = next_irq_status[`DPPIO_IRQ_A_MATCH] | match_evt_a;
      next_irq_status[`DPPIO_IRQ_B_XFER]  = next_irq_status[`DPPIO_IRQ_B_XFER]  | xfer_b;
      next_irq_status[`DPPIO_IRQ_B_MATCH] = next_irq_status[`DPPIO_IRQ_B_MATCH] | match_evt_b;
   end

   always @(posedge clk_i)
   begin
      if (reset_i)
         irq_status <= 4'h0;
      else
         irq_status <= next_irq_status;
   end

   assign pending = irq_status & irq_mask;
   assign pend_a  = pending[`DPPIO_IRQ_A_XFER] | pending[`DPPIO_IRQ_A_MATCH];
   assign pend_b  = pending[`DPPIO_IRQ_B_XFER] | pending[`DPPIO_IRQ_B_MATCH];

   // Bit 1 flags a pending source, bit 0 names it with A ahead of B.
   always @*
   begin
      case ({pend_a, pend_b})
         2'b00:   prio_code = 2'b00;
         2'b01:   prio_code = 2'b11;
         default: prio_code = 2'b10;
      endcase
   end

   // The chain input gates only the chain output, never the local interrupt line.
   assign int_o      = pend_a | pend_b;
   assign prio_out_o = prio_in_i & ~pend_a & ~pend_b;

   // Read data is captured in the setup cycle and shown in the access cycle.
   always @*
   begin
      next_prdata = 32'h0000_0000;
      if (ch_space && !sel_b)
         next_prdata[WIDTH-1:0] = chan_read(ch_ofs, in_data_a, mode_a,
                                            dir_a, mask_a, match_a);
      else if (ch_space)
         next_prdata[WIDTH-1:0] = chan_read(ch_ofs, in_data_b, mode_b,
                                            dir_b, mask_b, match_b);
      else if (hit_status)
         next_prdata[3:0] = irq_status;
      else if (hit_mask)
         next_prdata[3:0] = irq_mask;
      else if (hit_prio)
         next_prdata[1:0] = prio_code;
   end

   // An unmapped address flags an error for its access cycle; a write there changes nothing.
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
      else if (setup)
      begin
         prdata_o  <= next_prdata;
         pslverr_o <= ~mapped;
      end
   end

   // Channel A supports the bidirectional mode.
   dppio_chan
   #(
      .WIDTH (WIDTH),
      .BIDIR (1)
   )
   u_chan_a
   (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .mode_i       (mode_a),
      .dir_i        (dir_a),
      .mask_i       (mask_a),
      .match_i      (match_a),
      .host_wr_i    (wr_acc && hit_a_data),
      .host_wdata_i (pwdata_i[WIDTH-1:0]),
      .host_rd_i    (rd_setup && hit_a_data),
      .in_data_o    (in_data_a),
      .port_i       (porta_i),
      .port_o       (porta_o),
      .port_oe_n_o  (porta_oe_n_o),
      .stb_n_i      (stb_a_n_i),
      .rdy_o        (rdy_a_o),
      .xfer_evt_o   (xfer_a),
      .match_evt_o  (match_evt_a)
   );

   // Channel B: its mode register never holds the bidirectional code.
   dppio_chan
   #(
      .WIDTH (WIDTH),
      .BIDIR (0)
   )
   u_chan_b
   (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .mode_i       (mode_b),
      .dir_i        (dir_b),
      .mask_i       (mask_b),
      .match_i      (match_b),
      .host_wr_i    (wr_acc && hit_b_data),
      .host_wdata_i (pwdata_i[WIDTH-1:0]),
      .host_rd_i    (rd_setup && hit_b_data),
      .in_data_o    (in_data_b),
      .port_i       (portb_i),
      .port_o       (portb_o),
      .port_oe_n_o  (portb_oe_n_o),
      .stb_n_i      (stb_b_n_i),
      .rdy_o        (rdy_b_o),
      .xfer_evt_o   (xfer_b),
      .match_evt_o  (match_evt_b)
   );

endmodule

// ==== bench/dppio_top_sva.sv ====
// Checker of the pins, ready lines and priority chain of the parallel I/O block.
`timescale 1ns/10ps
module dppio_top_sva
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input wire             clk_i,
   input wire             reset_i,
   // Bus
   input wire             psel_i,
   input wire             penable_i,
   input wire             pwrite_i,
   // Channel pins
   input wire [WIDTH-1:0] porta_o,
   input wire [WIDTH-1:0] porta_oe_n_o,
   input wire             stb_a_n_i,
   input wire             rdy_a_o,
   input wire [WIDTH-1:0] portb_o,
   input wire             stb_b_n_i,
   input wire             rdy_b_o,
   // Interrupt chain
   input wire             int_o,
   input wire             prio_in_i,
   input wire             prio_out_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire wr = psel_i & penable_i & pwrite_i;

   reset_idle_a: assert property ($fell(reset_i) |-> &porta_oe_n_o && !rdy_a_o && !int_o)
      else $error("pins not idle after reset");
   prio_gate_a: assert property (prio_out_o == (prio_in_i && !int_o))
      else $error("priority out wrong");
   chain_block_a: assert property (!prio_in_i |-> !prio_out_o)
      else $error("priority out high with chain in low");
   rdy_a_clear_a: assert property ($fell(stb_a_n_i) && rdy_a_o && !psel_i |-> ##1 !rdy_a_o)
      else $error("ready A not cleared by strobe");
   rdy_b_clear_a: assert property ($fell(stb_b_n_i) && rdy_b_o && !psel_i |-> ##1 !rdy_b_o)
      else $error("ready B not cleared by strobe");
   porta_src_a: assert property ($changed(porta_o) |-> $past(wr))
      else $error("port A output changed without a write");
   portb_src_a: assert property ($changed(portb_o) |-> $past(wr))
      else $error("port B output changed without a write");
   rdy_b_rise_a: assert property ($rose(rdy_b_o) |-> $past(psel_i) || $past(psel_i, 2)
      || $past(psel_i, 3) || $past(reset_i, 2) || $past(reset_i, 3))
      else $error("ready B rose without cause");
endmodule

bind dppio_top dppio_top_sva #(.WIDTH(WIDTH)) dppio_top_sva_i (.clk_i, .reset_i, .psel_i,
   .penable_i, .pwrite_i, .porta_o, .porta_oe_n_o, .stb_a_n_i, .rdy_a_o, .portb_o,
   .stb_b_n_i, .rdy_b_o, .int_o, .prio_in_i, .prio_out_o);

// ==== bench/dppio_periph.sv ====
// Peripheral model that strobes bytes into and out of both channels.
`timescale 1ns/10ps
module dppio_periph
(
   // Clock
   input  wire        clk_i,
   // Pin levels
   input  wire [7:0]  pin_a_i,
   input  wire [7:0]  pin_b_i,
   // Driven levels and strobes
   output logic [7:0] drv_a_o,
   output logic [7:0] drv_b_o,
   output logic       stb_a_n_o,
   output logic       stb_b_n_o
);
   logic [7:0] seen_a;
   logic [7:0] seen_b;
   initial
   begin
      drv_a_o = 8'h00;
      drv_b_o = 8'h00;
      stb_a_n_o = 1'b1;
      stb_b_n_o = 1'b1;
   end
   task automatic put(input logic b, input logic [7:0] v);
      if (b)
         drv_b_o <= v;
      else
         drv_a_o <= v;
   endtask
   // The byte is held through the strobe, then inverted once its hold is over.
   task automatic strobe(input logic b, input logic [7:0] v, input int slow);
      put(b, v);
      repeat (slow + 1) @(posedge clk_i);
      if (b)
         stb_b_n_o <= 1'b0;
      else
         stb_a_n_o <= 1'b0;
      @(posedge clk_i);
      seen_a = pin_a_i;
      seen_b = pin_b_i;
      stb_a_n_o <= 1'b1;
      stb_b_n_o <= 1'b1;
      @(posedge clk_i);
      put(b, ~v);
   endtask
endmodule

// ==== bench/dppio_top_tb.sv ====
// Self-checking bench of the dual-channel parallel I/O block.
`timescale 1ns/10ps
`include "dppio_defines.vh"
module dppio_top_tb;
   localparam [7:0] A_DAT = `DPPIO_CH_A_BASE + `DPPIO_OFS_DATA;
   localparam [7:0] A_MOD = `DPPIO_CH_A_BASE + `DPPIO_OFS_MODE;
   localparam [7:0] A_DIR = `DPPIO_CH_A_BASE + `DPPIO_OFS_DIR;
   localparam [7:0] A_MSK = `DPPIO_CH_A_BASE + `DPPIO_OFS_MASK;
   localparam [7:0] A_MAT = `DPPIO_CH_A_BASE + `DPPIO_OFS_MATCH;
   localparam [7:0] B_DAT = `DPPIO_CH_B_BASE + `DPPIO_OFS_DATA;
   localparam [7:0] B_MOD = `DPPIO_CH_B_BASE + `DPPIO_OFS_MODE;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic        prio_in_i = 1'b1;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] rdat;
   logic        rerr;
   wire  [31:0] prdata_o;
   wire         pready_o, pslverr_o, rdy_a_o, rdy_b_o, int_o, prio_out_o, stb_a, stb_b;
   wire  [7:0]  porta_o, portb_o, oe_a, oe_b, drv_a, drv_b, pin_a, pin_b;
   int          err_total = 0;
   int          checks = 0;
   assign pin_a = (~oe_a & porta_o) | (oe_a & drv_a);
   assign pin_b = (~oe_b & portb_o) | (oe_b & drv_b);
   always #50 clk_i = ~clk_i;
   dppio_top dppio_top_i (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .porta_i(pin_a), .porta_o,
      .porta_oe_n_o(oe_a), .stb_a_n_i(stb_a), .rdy_a_o, .portb_i(pin_b), .portb_o,
      .portb_oe_n_o(oe_b), .stb_b_n_i(stb_b), .rdy_b_o, .int_o, .prio_in_i, .prio_out_o);
   dppio_periph dppio_periph_i (.clk_i, .pin_a_i(pin_a), .pin_b_i(pin_b),
      .drv_a_o(drv_a), .drv_b_o(drv_b), .stb_a_n_o(stb_a), .stb_b_n_o(stb_b));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      err_total++;
      end_of_test();
   end
   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(A_MOD, `DPPIO_MODE_RST);
      rd(B_MOD, `DPPIO_MODE_RST);
      rd(A_DIR, `DPPIO_DIR_RST);
      rd(A_MSK, `DPPIO_MASK_RST);
      rd(A_MAT, `DPPIO_MATCH_RST);
      rd(`DPPIO_IRQ_MASK, `DPPIO_IRQ_MASK_RST);
      chk(oe_a, 8'hff);
      chk(rdy_a_o, 1'b1);
      $display("test reset done");
      wr(`DPPIO_IRQ_MASK, 32'hf);
      dppio_periph_i.strobe(1'b0, 8'h5a, 0);
      repeat (2) @(posedge clk_i);
      chk(rdy_a_o, 1'b0);
      chk(int_o, 1'b1);
      chk(prio_out_o, 1'b0);
      dppio_periph_i.strobe(1'b0, 8'h11, 2);
      rd(`DPPIO_IRQ_STATUS, 32'h1);
      rd(A_DAT, 32'h5a);
      wr(`DPPIO_IRQ_STATUS, 32'h1);
      rd(`DPPIO_IRQ_STATUS, 32'h0);
      chk(rdy_a_o, 1'b1);
      $display("test input done");
      wr(B_MOD, `DPPIO_MODE_OUT);
      wr(B_DAT, 32'hc3);
      repeat (2) @(posedge clk_i);
      chk(oe_b, 8'h00);
      chk(portb_o, 8'hc3);
      chk(rdy_b_o, 1'b1);
      dppio_periph_i.strobe(1'b1, 8'h00, 3);
      chk(dppio_periph_i.seen_b, 8'hc3);
      repeat (2) @(posedge clk_i);
      chk(rdy_b_o, 1'b0);
      rd(`DPPIO_IRQ_STATUS, 32'h4);
      $display("test output done");
      dppio_periph_i.strobe(1'b0, 8'h33, 0);
      repeat (2) @(posedge clk_i);
      rd(`DPPIO_IRQ_PRIO, 32'h2);
      wr(`DPPIO_IRQ_STATUS, 32'h1);
      rd(`DPPIO_IRQ_PRIO, 32'h3);
      wr(`DPPIO_IRQ_STATUS, 32'h4);
      @(posedge clk_i);
      chk(int_o, 1'b0);
      rd(A_DAT, 32'h33);
      $display("test priority done");
      for (int m = 0; m < 4; m++)
      begin
         wr(A_MOD, m);
         rd(A_MOD, m);
      end
      wr(B_MOD, `DPPIO_MODE_BIT);
      wr(B_MOD, `DPPIO_MODE_BIDIR);
      rd(B_MOD, `DPPIO_MODE_BIT);
      chk(oe_b, 8'hff);
      $display("test modes done");
      wr(A_DIR, 32'h0f);
      wr(A_MSK, 32'h30);
      wr(A_MAT, 32'h80);
      wr(A_DAT, 32'ha5);
      @(posedge clk_i);
      chk(oe_a, 8'hf0);
      chk(porta_o, 8'ha5);
      chk(rdy_a_o, 1'b0);
      dppio_periph_i.put(1'b0, 8'h70);
      repeat (3) @(posedge clk_i);
      rd(`DPPIO_IRQ_STATUS, 32'h0);
      dppio_periph_i.put(1'b0, 8'hb0);
      repeat (3) @(posedge clk_i);
      rd(`DPPIO_IRQ_STATUS, 32'h2);
      prio_in_i <= 1'b0;
      @(posedge clk_i);
      chk(prio_out_o, 1'b0);
      wr(`DPPIO_IRQ_STATUS, 32'h2);
      prio_in_i <= 1'b1;
      @(posedge clk_i);
      chk(prio_out_o, 1'b1);
      rd(8'h3c, 32'h0);
      chk(rerr, 1'b1);
      $display("test bit mode done");
      end_of_test();
   end
endmodule
